// [design/tas_mode_seq.sv]
// touch converter mode sequencer with APB register slave
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
// Behaviour
// - mode 00 starts no conversion
// - decode mode 01 single, 10 slave, 11 master
// - mode 01 converts channel-code channel once
// - single done, timer 00: clear mode, idle
// - single with timer nonzero: repeat, keep mode
// - slave sequence converts enabled channels, stores results
// - slave end: timer 00 reverts, else reruns
// - master mode: wake on touch, then sequence
// - master restarts on new touch or timer
// - channel bits 10:7, selector bit 11
// - selector 0 single-ended, 1 ratiometric
// - codes 0 to 10 valid, above invalid
// - timer codes: once, 1024, 2048, 16384 clocks
// - slave timer starts at sequence end
// - master timer starts only if touched
// - release stops timer; next touch converts
// - mode field resets to 00
module tas_mode_seq #(
  parameter int TICK_CYCLES = tas_pkg::TICK_CYCLES,
  parameter int RPT1_TICKS = tas_pkg::RPT1_TICKS,
  parameter int RPT2_TICKS = tas_pkg::RPT2_TICKS,
  parameter int RPT3_TICKS = tas_pkg::RPT3_TICKS
) (
  input wire logic CLOCK_I,
  input wire logic RSTN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic TOUCH_I,
  input wire logic ADC_DONE_I,
  input wire logic [11:0] ADC_DATA_I,
  output logic ADC_START_O,
  output logic [3:0] ADC_CHAN_O,
  output logic ADC_RATIO_O,
  output tas_pkg::tas_drive_t DRIVE_O,
  output logic TOUCH_WAKE_EN_O,
  output logic RES_WE_O,
  output tas_pkg::tas_result_t RES_O,
  output logic BUSY_O
);

  logic [11:0] ctrl1_r;
  logic [11:0] ctrl2_r;
  logic [11:0] seq0_r;
  logic [11:0] seq1_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_val;
  logic rd_hit;
  logic commit;
  logic ctrl1_wr;
  logic touch_meta_r;
  logic touch_r;
  tas_pkg::tas_state_t state_r;
  tas_pkg::tas_state_t state_nxt;
  tas_pkg::tas_mode_t mode;
  logic [1:0] rpt_sel;
  logic [11:0] seq_sel;
  logic [3:0] chan_r;
  logic [3:0] chan_nxt;
  logic [3:0] idx_r;
  logic [3:0] idx_nxt;
  logic found;
  logic [3:0] found_ch;
  logic clr_mode;
  logic ratio_r;
  logic start_r;
  tas_pkg::tas_drive_t drive_r;
  logic wake_r;
  logic res_we_r;
  tas_pkg::tas_result_t res_r;
  logic busy_r;
  logic [6:0] tick_cnt_r;
  logic tick;
  logic [14:0] ivl_cnt_r;
  logic [14:0] ivl_lim;
  logic ivl_exp;

  assign mode = tas_pkg::tas_mode_t'(ctrl1_r[tas_pkg::MODE_LSB +: 2]);
  assign rpt_sel = ctrl2_r[tas_pkg::RPT_SEL_LSB +: 2];
  assign seq_sel = (mode == tas_pkg::MODE_MASTER_SEQ) ? seq1_r : seq0_r;

  // apb: one wait state, so every answer comes from a flop
  assign commit = PSEL_I && PENABLE_I && pready_r;
  assign ctrl1_wr = commit && PWRITE_I && (PADDR_I == tas_pkg::CTRL1_OFS);

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (PADDR_I)
      tas_pkg::CTRL1_OFS: rd_val[11:0] = ctrl1_r;
      tas_pkg::CTRL2_OFS: rd_val[11:0] = ctrl2_r;
      tas_pkg::SEQ0_OFS: rd_val[11:0] = seq0_r;
      tas_pkg::SEQ1_OFS: rd_val[11:0] = seq1_r;
      tas_pkg::STAT_OFS: begin
        rd_val[0] = busy_r;
        rd_val[1] = touch_r;
        rd_val[2] = wake_r;
        rd_val[tas_pkg::STAT_CHAN_LSB +: 4] = chan_r;
        rd_val[tas_pkg::STAT_IDX_LSB +: 4] = idx_r;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= PSEL_I && PENABLE_I && !pready_r;
      if (PSEL_I && PENABLE_I && !pready_r) begin
        prdata_r <= PWRITE_I ? 32'h0000_0000 : rd_val;
        pslverr_r <= !rd_hit;
      end
    end
  end

  // a host write of control one wins over the hardware mode clear: it is a new command
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      // mode field at 00 from reset
      ctrl1_r <= tas_pkg::CTRL1_RST;
    end else if (ctrl1_wr) begin
      ctrl1_r <= PWDATA_I[11:0];
    end else if (clr_mode) begin
      ctrl1_r[tas_pkg::MODE_LSB +: 2] <= tas_pkg::MODE_OFF;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      ctrl2_r <= tas_pkg::CTRL2_RST;
      seq0_r <= tas_pkg::SEQ_RST;
      seq1_r <= tas_pkg::SEQ_RST;
    end else if (commit && PWRITE_I) begin
      if (PADDR_I == tas_pkg::CTRL2_OFS) ctrl2_r <= PWDATA_I[11:0];
      if (PADDR_I == tas_pkg::SEQ0_OFS) seq0_r <= PWDATA_I[11:0];
      if (PADDR_I == tas_pkg::SEQ1_OFS) seq1_r <= PWDATA_I[11:0];
    end
  end

  // touch detector is asynchronous to this clock
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      touch_meta_r <= 1'b0;
      touch_r <= 1'b0;
    end else begin
      touch_meta_r <= TOUCH_I;
      touch_r <= touch_meta_r;
    end
  end

  // lowest enabled channel at or above the sequence index
  always_comb begin
    found = 1'b0;
    found_ch = 4'h0;
    for (int c = 10; c >= 0; c--) begin
      if (seq_sel[tas_pkg::SEQ_TOP_BIT - c] && (4'(c) >= idx_r)) begin
        found = 1'b1;
        found_ch = 4'(c);
      end
    end
  end

  // repeat interval in conversion clocks
  always_comb begin
    unique case (rpt_sel)
      2'h1: ivl_lim = 15'(RPT1_TICKS - 1);
      2'h2: ivl_lim = 15'(RPT2_TICKS - 1);
      default: ivl_lim = 15'(RPT3_TICKS - 1);
    endcase
  end

  assign tick = (tick_cnt_r == 7'(TICK_CYCLES - 1));
  assign ivl_exp = (state_r == tas_pkg::ST_INTERVAL) && tick && (ivl_cnt_r == ivl_lim);

  // interval counter restarts on each entry, so every wait is exact
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I || state_r != tas_pkg::ST_INTERVAL) begin
      tick_cnt_r <= 7'h00;
      ivl_cnt_r <= 15'h0000;
    end else begin
      tick_cnt_r <= tick ? 7'h00 : tick_cnt_r + 7'h01;
      if (tick) ivl_cnt_r <= ivl_cnt_r + 15'h0001;
    end
  end

  always_comb begin
    state_nxt = state_r;
    chan_nxt = chan_r;
    idx_nxt = idx_r;
    clr_mode = 1'b0;
    // a control one write aborts and redecodes
    if (ctrl1_wr) begin
      state_nxt = tas_pkg::ST_IDLE;
    end else if (mode == tas_pkg::MODE_OFF) begin
      state_nxt = tas_pkg::ST_IDLE;
    end else begin
      unique case (state_r)
        tas_pkg::ST_IDLE: begin
          idx_nxt = 4'h0;
          unique case (mode)
            tas_pkg::MODE_SINGLE: begin
              // single channel, invalid codes skip conversion
              chan_nxt = ctrl1_r[tas_pkg::CHAN_LSB +: 4];
              state_nxt = (chan_nxt <= tas_pkg::CHAN_MAX) ? tas_pkg::ST_START : tas_pkg::ST_END;
            end
            tas_pkg::MODE_SLAVE_SEQ: state_nxt = tas_pkg::ST_PICK;
            default: state_nxt = tas_pkg::ST_WAIT_TOUCH;
          endcase
        end
        tas_pkg::ST_WAIT_TOUCH: begin
          idx_nxt = 4'h0;
          if (touch_r) state_nxt = tas_pkg::ST_PICK;
        end
        tas_pkg::ST_PICK: begin
          chan_nxt = found_ch;
          state_nxt = found ? tas_pkg::ST_START : tas_pkg::ST_END;
        end
        tas_pkg::ST_START: state_nxt = tas_pkg::ST_WAIT_DONE;
        tas_pkg::ST_WAIT_DONE: begin
          if (ADC_DONE_I) begin
            idx_nxt = chan_r + 4'h1;
            state_nxt = (mode == tas_pkg::MODE_SINGLE) ? tas_pkg::ST_END : tas_pkg::ST_PICK;
          end
        end
        tas_pkg::ST_END: begin
          if (mode == tas_pkg::MODE_MASTER_SEQ) begin
            state_nxt = (touch_r && rpt_sel != 2'h0) ? tas_pkg::ST_INTERVAL
                                                 : tas_pkg::ST_WAIT_RELEASE;
          end else if (rpt_sel == 2'h0) begin
            clr_mode = 1'b1;
            state_nxt = tas_pkg::ST_IDLE;
          end else begin
            state_nxt = tas_pkg::ST_INTERVAL;
          end
        end
        // a fresh touch needs a release first
        tas_pkg::ST_WAIT_RELEASE: begin
          if (!touch_r) state_nxt = tas_pkg::ST_WAIT_TOUCH;
        end
        tas_pkg::ST_INTERVAL: begin
          if (mode == tas_pkg::MODE_MASTER_SEQ && !touch_r) begin
            state_nxt = tas_pkg::ST_WAIT_TOUCH;
          end else if (ivl_exp) begin
            state_nxt = tas_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      state_r <= tas_pkg::ST_IDLE;
      chan_r <= 4'h0;
      idx_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      chan_r <= chan_nxt;
      idx_r <= idx_nxt;
    end
  end

  // switch and reference drive for a channel
  function automatic tas_pkg::tas_drive_t drive_of(input logic [3:0] ch, input logic ratio);
    tas_pkg::tas_drive_t d;
    d = '{1'b0, 1'b0, 1'b0, 1'b0, tas_pkg::REF_VREF, tas_pkg::REF_GND};
    unique case (ch)
      4'h0: d = '{1'b0, 1'b0, 1'b1, 1'b1, tas_pkg::REF_YP, tas_pkg::REF_YM};
      4'h1: d = '{1'b1, 1'b1, 1'b0, 1'b0, tas_pkg::REF_XP, tas_pkg::REF_XM};
      4'h2, 4'hA: d = '{1'b0, 1'b1, 1'b1, 1'b0, tas_pkg::REF_YP, tas_pkg::REF_XM};
      default: d.xp_on = 1'b0;
    endcase
    if (!ratio) begin
      d.ref_pos = tas_pkg::REF_VREF;
      d.ref_neg = tas_pkg::REF_GND;
    end
    return d;
  endfunction : drive_of

  // drive is loaded together with the start pulse and held until done,
  // so the plates have settled before the converter samples
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      start_r <= 1'b0;
      ratio_r <= 1'b0;
      drive_r <= '{1'b0, 1'b0, 1'b0, 1'b0, tas_pkg::REF_VREF, tas_pkg::REF_GND};
    end else begin
      start_r <= (state_r == tas_pkg::ST_START);
      if (state_r == tas_pkg::ST_START) begin
        ratio_r <= ctrl1_r[tas_pkg::RATIO_BIT];
        drive_r <= drive_of(chan_r, ctrl1_r[tas_pkg::RATIO_BIT]);
      end else if (state_r != tas_pkg::ST_WAIT_DONE) begin
        drive_r <= '{1'b0, 1'b0, 1'b0, 1'b0, tas_pkg::REF_VREF, tas_pkg::REF_GND};
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      res_we_r <= 1'b0;
      res_r <= '{4'h0, 12'h000};
    end else begin
      res_we_r <= (state_r == tas_pkg::ST_WAIT_DONE) && ADC_DONE_I;
      if (state_r == tas_pkg::ST_WAIT_DONE && ADC_DONE_I) res_r <= '{chan_r, ADC_DATA_I};
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      wake_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      wake_r <= (mode == tas_pkg::MODE_MASTER_SEQ);
      busy_r <= (state_nxt != tas_pkg::ST_IDLE);
    end
  end

  assign PRDATA_O = prdata_r;
  assign PREADY_O = pready_r;
  assign PSLVERR_O = pslverr_r;
  assign ADC_START_O = start_r;
  assign ADC_CHAN_O = chan_r;
  assign ADC_RATIO_O = ratio_r;
  assign DRIVE_O = drive_r;
  assign TOUCH_WAKE_EN_O = wake_r;
  assign RES_WE_O = res_we_r;
  assign RES_O = res_r;
  assign BUSY_O = busy_r;

  // checks
  int unsigned ivl_cyc;
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I || state_r != tas_pkg::ST_INTERVAL) ivl_cyc <= 0;
    else ivl_cyc <= ivl_cyc + 1;
  end

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RSTN_I);

  a_off_no_start: assert property (ADC_START_O |-> $past(mode) != tas_pkg::MODE_OFF)
    else $error("conversion started in mode 00");
  a_single_chan: assert property (
    ADC_START_O && mode == tas_pkg::MODE_SINGLE |-> ADC_CHAN_O == ctrl1_r[10:7])
    else $error("single conversion on wrong channel");
  a_single_clear: assert property (
    state_r == tas_pkg::ST_END && mode != tas_pkg::MODE_MASTER_SEQ && rpt_sel == 2'h0
    && !ctrl1_wr |=> mode == tas_pkg::MODE_OFF && state_r == tas_pkg::ST_IDLE)
    else $error("one-shot did not revert mode");
  a_repeat_keep: assert property (
    state_r == tas_pkg::ST_END && mode != tas_pkg::MODE_MASTER_SEQ && rpt_sel != 2'h0
    && !ctrl1_wr |=> $stable(mode) ##0 state_r == tas_pkg::ST_INTERVAL)
    else $error("repeat lost mode or timer");
  a_seq_enabled: assert property (
    ADC_START_O && mode != tas_pkg::MODE_SINGLE |-> seq_sel[4'd11 - ADC_CHAN_O])
    else $error("converted a channel not enabled");
  a_chan_valid: assert property (ADC_START_O |-> ADC_CHAN_O <= 4'hA)
    else $error("invalid channel converted");
  a_ratio_ref: assert property (
    ADC_START_O && !ADC_RATIO_O |-> DRIVE_O.ref_pos == tas_pkg::REF_VREF
    && DRIVE_O.ref_neg == tas_pkg::REF_GND)
    else $error("single-ended conversion with plate reference");
  a_touch_start: assert property (
    state_r == tas_pkg::ST_WAIT_TOUCH && touch_r && !ctrl1_wr
    && mode == tas_pkg::MODE_MASTER_SEQ |=> state_r == tas_pkg::ST_PICK ##0 wake_r)
    else $error("touch did not start master sequence");
  a_ivl_length: assert property (
    ivl_exp |-> ivl_cyc == 32'(TICK_CYCLES) * (32'(ivl_lim) + 32'd1) - 32'd1)
    else $error("repeat interval length wrong");
  a_master_notouch: assert property (
    state_r == tas_pkg::ST_END && mode == tas_pkg::MODE_MASTER_SEQ && !touch_r
    |=> state_r != tas_pkg::ST_INTERVAL)
    else $error("master timer started without touch");
  a_release_stop: assert property (
    state_r == tas_pkg::ST_INTERVAL && mode == tas_pkg::MODE_MASTER_SEQ && !touch_r
    && !ctrl1_wr |=> state_r == tas_pkg::ST_WAIT_TOUCH)
    else $error("release did not stop timer");
  a_drive_hold: assert property (
    state_r == tas_pkg::ST_WAIT_DONE && $past(state_r) == tas_pkg::ST_WAIT_DONE
    |-> $stable(DRIVE_O))
    else $error("drive changed during conversion");

  c_single: cover property (mode == tas_pkg::MODE_SINGLE ##1 RES_WE_O ##[1:4] clr_mode);
  c_slave_repeat: cover property (mode == tas_pkg::MODE_SLAVE_SEQ && ivl_exp);
  c_master_timer: cover property (mode == tas_pkg::MODE_MASTER_SEQ && ivl_exp);

endmodule : tas_mode_seq

// [design/tas_pkg.sv]
// constants, types and register map of the touch converter mode sequencer
package tas_pkg;

  // register byte offsets on the APB bus
  localparam logic [11:0] CTRL1_OFS = 12'h000;
  localparam logic [11:0] CTRL2_OFS = 12'h004;
  localparam logic [11:0] SEQ0_OFS = 12'h008;
  localparam logic [11:0] SEQ1_OFS = 12'h00C;
  localparam logic [11:0] STAT_OFS = 12'h010;

  // reset values
  localparam logic [11:0] CTRL1_RST = 12'h000;
  localparam logic [11:0] CTRL2_RST = 12'h000;
  localparam logic [11:0] SEQ_RST = 12'h000;

  // field positions
  localparam int MODE_LSB = 0;
  localparam int CHAN_LSB = 7;
  localparam int RATIO_BIT = 11;
  localparam int RPT_SEL_LSB = 0;
  localparam int SEQ_TOP_BIT = 11;
  localparam int STAT_CHAN_LSB = 4;
  localparam int STAT_IDX_LSB = 8;

  // highest valid channel code
  localparam logic [3:0] CHAN_MAX = 4'hA;

  // conversion clock and repeat intervals
  localparam int CLK_PERIOD_NS = 5;
  localparam int CONV_CLK_NS = 500;
  localparam int TICK_CYCLES = (CONV_CLK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RPT1_TICKS = 1024;
  localparam int RPT2_TICKS = 2048;
  localparam int RPT3_TICKS = 16384;

  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_SINGLE = 2'h1,
    MODE_SLAVE_SEQ = 2'h2,
    MODE_MASTER_SEQ = 2'h3
  } tas_mode_t;

  typedef enum logic [2:0] {REF_VREF, REF_GND, REF_XP, REF_XM, REF_YP, REF_YM} tas_ref_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT_TOUCH, ST_PICK, ST_START, ST_WAIT_DONE, ST_END, ST_WAIT_RELEASE,
    ST_INTERVAL
  } tas_state_t;

  // plate switches and reference selection for one conversion
  typedef struct packed {
    logic xp_on;
    logic xm_on;
    logic yp_on;
    logic ym_on;
    tas_ref_t ref_pos;
    tas_ref_t ref_neg;
  } tas_drive_t;

  typedef struct packed {
    logic [3:0] chan;
    logic [11:0] data;
  } tas_result_t;

endpackage : tas_pkg

// [verification/tas_mode_seq_tb.sv]
// self-checking testbench for the touch converter mode sequencer
`timescale 1ns/1ps
module tas_mode_seq_tb;
  // shortened interval counts keep the repeat tests brief
  localparam int TICK = 2;
  localparam int RPT[4] = '{0, 4, 8, 16};
  localparam int LIMIT = 20000;
  logic clk, rstn, psel, penable, pwrite, touch, adc_done;
  logic [11:0] paddr, adc_data;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, adc_start, adc_ratio, wake_en, res_we, busy;
  logic [3:0] adc_chan;
  tas_pkg::tas_drive_t drive;
  tas_pkg::tas_result_t res;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int gap;

  tas_mode_seq #(.TICK_CYCLES(TICK), .RPT1_TICKS(RPT[1]), .RPT2_TICKS(RPT[2]),
    .RPT3_TICKS(RPT[3])) dut (
    .CLOCK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .TOUCH_I(touch), .ADC_DONE_I(adc_done), .ADC_DATA_I(adc_data),
    .ADC_START_O(adc_start), .ADC_CHAN_O(adc_chan), .ADC_RATIO_O(adc_ratio), .DRIVE_O(drive),
    .TOUCH_WAKE_EN_O(wake_en), .RES_WE_O(res_we), .RES_O(res), .BUSY_O(busy)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic report_and_stop;
    if (errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  // a hang ends the run through the same closing report
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      errors = errors + 1;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // switch and reference pattern expected for a channel code
  function automatic tas_pkg::tas_drive_t exp_drive(input logic [3:0] ch, input logic r);
    tas_pkg::tas_drive_t d;
    d = '{1'b0, 1'b0, 1'b0, 1'b0, tas_pkg::REF_VREF, tas_pkg::REF_GND};
    case (ch)
      4'h0: d = '{1'b0, 1'b0, 1'b1, 1'b1, tas_pkg::REF_YP, tas_pkg::REF_YM};
      4'h1: d = '{1'b1, 1'b1, 1'b0, 1'b0, tas_pkg::REF_XP, tas_pkg::REF_XM};
      4'h2, 4'hA: d = '{1'b0, 1'b1, 1'b1, 1'b0, tas_pkg::REF_YP, tas_pkg::REF_XM};
      default: ;
    endcase
    if (!r) begin
      d.ref_pos = tas_pkg::REF_VREF;
      d.ref_neg = tas_pkg::REF_GND;
    end
    return d;
  endfunction : exp_drive

  // one APB transfer; the request stands until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [11:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, {20'h0, d}, rd, err);
    chk(32'(err), 32'h0);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, exp);
    chk(32'(err), 32'(exp_err));
  endtask : rd_chk

  task automatic no_start(input int n);
    repeat (n) begin
      @(posedge clk);
      chk(32'(adc_start), 32'h0);
    end
  endtask : no_start

  task automatic wait_start(input int mx, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n = n + 1;
    end while (adc_start !== 1'b1 && n < mx);
    chk(32'(adc_start), 32'h1);
  endtask : wait_start

  // converter side: checks the set-up of a started conversion, answers after lat cycles
  task automatic conv(input logic [3:0] ch, input logic r, input int lat);
    logic [11:0] dat;
    dat = {ch, 7'h2B, r};
    chk(32'(adc_chan), 32'(ch));
    chk(32'(adc_ratio), 32'(r));
    chk(32'(drive), 32'(exp_drive(ch, r)));
    repeat (lat) begin
      @(posedge clk);
      chk(32'(drive), 32'(exp_drive(ch, r)));
    end
    adc_done <= 1'b1;
    adc_data <= dat;
    @(posedge clk);
    adc_done <= 1'b0;
    adc_data <= ~dat;
    @(posedge clk);
    chk(32'(res_we), 32'h1);
    chk(32'(res), 32'({ch, dat}));
  endtask : conv

  // slave sequence over channels 0, 5 and 10; the caller waits for the first start
  task automatic run_seq(input logic r);
    conv(4'h0, r, 1);
    wait_start(12, gap);
    conv(4'h5, r, 0);
    wait_start(12, gap);
    conv(4'hA, r, 2);
  endtask : run_seq

  initial begin
    {psel, penable, pwrite, touch, adc_done} = '0;
    paddr = '0;
    pwdata = '0;
    adc_data = '0;
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(tas_pkg::CTRL1_OFS, 32'h0, 1'b0);
    rd_chk(tas_pkg::CTRL2_OFS, 32'h0, 1'b0);
    rd_chk(tas_pkg::SEQ0_OFS, 32'h0, 1'b0);
    rd_chk(tas_pkg::SEQ1_OFS, 32'h0, 1'b0);
    rd_chk(12'h014, 32'h0, 1'b1);
    no_start(20);
    // every valid code in both conversion kinds, single shot then idle
    for (int c = 0; c < 11; c++) begin
      for (int r = 0; r < 2; r++) begin
        wr(tas_pkg::CTRL1_OFS, {r[0], c[3:0], 5'h0, 2'h1});
        wait_start(12, gap);
        conv(c[3:0], r[0], c % 3);
        no_start(6);
        chk(32'(busy), 32'h0);
        rd_chk(tas_pkg::CTRL1_OFS, {20'h0, r[0], c[3:0], 7'h0}, 1'b0);
      end
    end
    for (int c = 11; c < 16; c++) begin
      wr(tas_pkg::CTRL1_OFS, {1'b0, c[3:0], 5'h0, 2'h1});
      no_start(20);
      rd_chk(tas_pkg::CTRL1_OFS, {20'h0, 1'b0, c[3:0], 7'h0}, 1'b0);
    end
    // each repeat code measured from end of one conversion to the next start
    for (int t = 1; t < 4; t++) begin
      wr(tas_pkg::CTRL2_OFS, 12'(t));
      wr(tas_pkg::CTRL1_OFS, {1'b0, 4'h3, 5'h0, 2'h1});
      wait_start(12, gap);
      conv(4'h3, 1'b0, 0);
      wait_start(TICK * RPT[t] + 7, gap);
      chk(32'(gap >= TICK * RPT[t]), 32'h1);
      conv(4'h3, 1'b0, 0);
      rd_chk(tas_pkg::CTRL1_OFS, {20'h0, 1'b0, 4'h3, 7'h1}, 1'b0);
      wr(tas_pkg::CTRL1_OFS, 12'h000);
      no_start(TICK * RPT[t] + 10);
    end
    // slave sequence, repeated while the timer runs, then single pass
    wr(tas_pkg::SEQ0_OFS, 12'h842);
    wr(tas_pkg::CTRL2_OFS, 12'h001);
    wr(tas_pkg::CTRL1_OFS, 12'h802);
    wait_start(12, gap);
    run_seq(1'b1);
    // the rerun waits one full interval after the sequence end
    wait_start(TICK * RPT[1] + 7, gap);
    chk(32'(gap >= TICK * RPT[1]), 32'h1);
    run_seq(1'b1);
    wr(tas_pkg::CTRL1_OFS, 12'h000);
    wr(tas_pkg::CTRL2_OFS, 12'h000);
    wr(tas_pkg::CTRL1_OFS, 12'h002);
    wait_start(12, gap);
    run_seq(1'b0);
    no_start(30);
    rd_chk(tas_pkg::CTRL1_OFS, 32'h0, 1'b0);
    // master sequence gated by touch
    wr(tas_pkg::SEQ1_OFS, 12'h400);
    wr(tas_pkg::CTRL2_OFS, 12'h001);
    wr(tas_pkg::CTRL1_OFS, 12'h003);
    no_start(30);
    chk(32'(wake_en), 32'h1);
    chk(32'(busy), 32'h1);
    touch <= 1'b1;
    wait_start(12, gap);
    conv(4'h1, 1'b0, 1);
    wait_start(TICK * RPT[1] + 7, gap);
    chk(32'(gap >= TICK * RPT[1]), 32'h1);
    conv(4'h1, 1'b0, 0);
    @(posedge clk);
    touch <= 1'b0;
    no_start(60);
    touch <= 1'b1;
    wait_start(12, gap);
    // released before the sequence ends: no timer, wait for a fresh touch
    touch <= 1'b0;
    conv(4'h1, 1'b0, 4);
    no_start(40);
    chk(32'(busy), 32'h1);
    touch <= 1'b1;
    wait_start(12, gap);
    conv(4'h1, 1'b0, 0);
    touch <= 1'b0;
    wr(tas_pkg::CTRL1_OFS, 12'h000);
    no_start(40);
    report_and_stop();
  end
endmodule : tas_mode_seq_tb
